// File: hw/lucc_common_ctrl.v
`timescale 1ns/10ps
`include "lucc_ctrl_map.vh"
// Common control register one with its serial host port
module lucc_common_ctrl #(
    parameter ERR_WIDTH = 16,
    parameter TX_LOSS_CYCLES = `LUCC_TX_LOSS_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Serial host port pins
    input wire chipSelN,
    input wire serialClk,
    input wire serialIn,
    output reg serialOut,
    output reg serialOutEn,
    input wire inputEdgeSelect,
    input wire outputEdgeSelect,
    // Line clocks as pins
    input wire masterClockIn,
    input wire pllClockIn,
    input wire transmitClockIn,
    input wire rxClockIn,
    // Receive bit stream, same clock domain
    input wire rxBitStrobe,
    input wire rxBitZero,
    // Error event, same clock domain
    input wire errorEvent,
    // Outputs
    output reg [7:0] commonControlOne,
    output reg lineStandardT1,
    output reg receiveCarrierLoss,
    output reg [ERR_WIDTH-1:0] errorCountSnap,
    output reg attenuatorClock,
    output reg rxClockPath,
    output reg txLogicClock,
    output reg txClockLost
);

    // Synchronised pins
    wire [8:0] syncBus;
    wire csNS;
    wire sclkS;
    wire sdiS;
    wire icesS;
    wire ocesS;
    wire mclkS;
    wire pllS;
    wire tclkS;
    wire rclkS;

    // Serial port state
    reg sclkPrev_q;
    reg [7:0] inShift_q;
    reg [2:0] bitCnt_q;
    reg inData_q;        // Past the command byte
    reg isRead_q;
    reg isBurst_q;
    reg [4:0] addr_q;
    reg [7:0] outShift_q;
    reg portDone_q;      // Access over: single data byte done, or burst ran past its last address

    // Carrier loss, counter and clock state
    reg [11:0] zeroCnt_q;
    reg trigPrev_q;
    reg [ERR_WIDTH-1:0] errRun_q;
    reg tclkPrev_q;
    reg [15:0] idleCnt_q;

    // Decoded edges and thresholds
    wire sclkRise;
    wire sclkFall;
    wire sampleEdge;
    wire outputEdge;
    wire byteDone;
    wire [7:0] byteNow;
    reg [11:0] zeroLimit;
    reg [11:0] zeroCnt_d;      // Zero run after this cycle's bit
    reg [7:0] readData;
    reg [4:0] fetchAddr;       // Address of the byte loaded at a boundary

    // All pins but the receive bit and error inputs pass two flops before any logic reads them
    lucc_sync #(
        .WIDTH(9)
    ) uSync (
        .clock(clock),
        .rst_n(rst_n),
        .asyncIn({chipSelN, serialClk, serialIn, inputEdgeSelect, outputEdgeSelect,
            masterClockIn, pllClockIn, transmitClockIn, rxClockIn}),
        .syncOut(syncBus)
    );

    assign csNS = syncBus[8];
    assign sclkS = syncBus[7];
    assign sdiS = syncBus[6];
    assign icesS = syncBus[5];
    assign ocesS = syncBus[4];
    assign mclkS = syncBus[3];
    assign pllS = syncBus[2];
    assign tclkS = syncBus[1];
    assign rclkS = syncBus[0];

    // Serial clock edges seen from the system clock
    assign sclkRise = sclkS & ~sclkPrev_q;
    assign sclkFall = ~sclkS & sclkPrev_q;
    // Low input select samples on rising, high on falling
    assign sampleEdge = icesS ? sclkFall : sclkRise;
    // Low output select updates on falling, high on rising
    assign outputEdge = ocesS ? sclkRise : sclkFall;
    // Serial data arrives LSB first, so it shifts in from the top
    assign byteNow = {sdiS, inShift_q[7:1]};
    assign byteDone = ~csNS & sampleEdge & (bitCnt_q == 3'h7);

    // A byte loaded at a boundary belongs to the address that comes next:
    // the new command's address, or the following burst address
    always @* begin
        if (!inData_q) begin
            if (byteNow[`LUCC_CMD_BURST]) begin
                fetchAddr = 5'h00;
            end else begin
                fetchAddr = byteNow[`LUCC_CMD_ADDR_HI:`LUCC_CMD_ADDR_LO];
            end
        end else begin
            fetchAddr = addr_q + 5'h01;
        end
    end

    // Only common_control_one is held here; other addresses read as zero
    always @* begin
        if (fetchAddr == `LUCC_ADDR_COMMON_CONTROL_ONE) begin
            readData = commonControlOne;
        end else begin
            readData = 8'h00;
        end
    end

    // Serial port: command byte, then data bytes
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrev_q <= 1'b0;
            inShift_q <= 8'h00;
            bitCnt_q <= 3'h0;
            inData_q <= 1'b0;
            isRead_q <= 1'b0;
            isBurst_q <= 1'b0;
            addr_q <= 5'h00;
            outShift_q <= 8'h00;
            portDone_q <= 1'b0;
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
        end else begin
            sclkPrev_q <= sclkS;
            if (csNS) begin
                // Chip select high aborts and floats the output
                bitCnt_q <= 3'h0;
                inData_q <= 1'b0;
                isRead_q <= 1'b0;
                portDone_q <= 1'b0;
                serialOutEn <= 1'b0;
            end else begin
                if (sampleEdge) begin
                    inShift_q <= byteNow;
                    bitCnt_q <= bitCnt_q + 3'h1;
                end
                if (byteDone && !inData_q) begin
                    // Command byte: rw flag, five address bits, burst flag
                    inData_q <= 1'b1;
                    isRead_q <= byteNow[`LUCC_CMD_RW];
                    isBurst_q <= byteNow[`LUCC_CMD_BURST];
                    // Burst always starts from address zero
                    if (byteNow[`LUCC_CMD_BURST]) begin
                        addr_q <= 5'h00;
                    end else begin
                        addr_q <= byteNow[`LUCC_CMD_ADDR_HI:`LUCC_CMD_ADDR_LO];
                    end
                end else if (byteDone && inData_q) begin
                    // Data byte finished; burst steps, single access stops
                    if (!isBurst_q) begin
                        portDone_q <= 1'b1;
                    end else if (isRead_q && addr_q == `LUCC_ADDR_LAST_READ) begin
                        portDone_q <= 1'b1;
                    end else if (!isRead_q && addr_q == `LUCC_ADDR_LAST_WRITE) begin
                        portDone_q <= 1'b1;
                    end else begin
                        addr_q <= addr_q + 5'h01;
                    end
                end
                // Output side: load a byte at each boundary, shift on output edges
                if (inData_q && isRead_q && !portDone_q) begin
                    if (outputEdge) begin
                        serialOut <= outShift_q[0];
                        serialOutEn <= 1'b1;
                        outShift_q <= {1'b0, outShift_q[7:1]};
                    end
                end else begin
                    serialOutEn <= 1'b0;
                end
                if (byteDone) begin
                    // Next read byte is fetched at the byte boundary
                    outShift_q <= readData;
                end
            end
        end
    end

    // Register write on the last data bit of a write byte
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            commonControlOne <= `LUCC_RESET_COMMON_CONTROL_ONE;
        end else if (byteDone && inData_q && !isRead_q && !portDone_q) begin
            if (addr_q == `LUCC_ADDR_COMMON_CONTROL_ONE) begin
                commonControlOne <= byteNow;
            end
        end
    end

    // Line standard is bit 7: clear E1, set T1
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lineStandardT1 <= 1'b0;
        end else begin
            lineStandardT1 <= commonControlOne[`LUCC_BIT_LINE_STANDARD];
        end
    end

    // Zero-run threshold from line standard and criteria bit
    always @* begin
        case ({commonControlOne[`LUCC_BIT_CARRIER_ALT],
               commonControlOne[`LUCC_BIT_LINE_STANDARD]})
            2'b00: zeroLimit = `LUCC_ZEROS_E1;
            2'b01: zeroLimit = `LUCC_ZEROS_T1;
            2'b10: zeroLimit = `LUCC_ZEROS_E1_ALT;
            default: zeroLimit = `LUCC_ZEROS_T1_ALT;
        endcase
    end

    // Next zero run; a one bit ends the run
    always @* begin
        zeroCnt_d = zeroCnt_q;
        if (rxBitStrobe) begin
            if (!rxBitZero) begin
                zeroCnt_d = 12'h000;
            end else if (zeroCnt_q != 12'hFFF) begin
                // Saturate so a long silence never wraps to no loss
                zeroCnt_d = zeroCnt_q + 12'h001;
            end
        end
    end

    // Loss follows the run itself, so a one bit clears it together with
    // the run and a stale count can never set it again
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            zeroCnt_q <= 12'h000;
            receiveCarrierLoss <= 1'b0;
        end else begin
            zeroCnt_q <= zeroCnt_d;
            // Threshold changes take effect without waiting for a new bit
            receiveCarrierLoss <= (zeroCnt_d >= zeroLimit);
        end
    end

    // Error counter snapshot on a rising update bit
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trigPrev_q <= 1'b0;
            errRun_q <= {ERR_WIDTH{1'b0}};
            errorCountSnap <= {ERR_WIDTH{1'b0}};
        end else begin
            trigPrev_q <= commonControlOne[`LUCC_BIT_COUNT_UPDATE];
            if (commonControlOne[`LUCC_BIT_COUNT_UPDATE] && !trigPrev_q) begin
                // Copy and clear; an error in this very cycle is kept
                errorCountSnap <= errRun_q;
                errRun_q <= {{(ERR_WIDTH-1){1'b0}}, errorEvent};
            end else if (errorEvent && errRun_q != {ERR_WIDTH{1'b1}}) begin
                errRun_q <= errRun_q + {{(ERR_WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Transmit clock activity watchdog
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tclkPrev_q <= 1'b0;
            idleCnt_q <= 16'h0000;
            txClockLost <= 1'b0;
        end else begin
            tclkPrev_q <= tclkS;
            if (tclkS != tclkPrev_q) begin
                idleCnt_q <= 16'h0000;
                txClockLost <= 1'b0;
            end else if (idleCnt_q >= TX_LOSS_CYCLES[15:0] - 16'h0001) begin
                txClockLost <= 1'b1;
            end else begin
                idleCnt_q <= idleCnt_q + 16'h0001;
            end
        end
    end

    // Clock steering; the host keeps mux and standard consistent with the master clock
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            attenuatorClock <= 1'b0;
            rxClockPath <= 1'b0;
            txLogicClock <= 1'b0;
        end else begin
            if (commonControlOne[`LUCC_BIT_TX_TO_ATTEN]) begin
                attenuatorClock <= tclkS;
            end else if (commonControlOne[`LUCC_BIT_ATTEN_MUX]) begin
                attenuatorClock <= pllS;
            end else begin
                attenuatorClock <= mclkS;
            end
            if (commonControlOne[`LUCC_BIT_TX_TO_RX]) begin
                rxClockPath <= tclkS;
            end else begin
                rxClockPath <= rclkS;
            end
            // Fallback only when enabled and the transmit clock has stopped
            if (commonControlOne[`LUCC_BIT_TX_FALLBACK] && txClockLost) begin
                txLogicClock <= attenuatorClock;
            end else begin
                txLogicClock <= tclkS;
            end
        end
    end

endmodule

// File: hw/lucc_ctrl_map.vh
// Overview of operation
// - Normal criteria: 255 zeros E1, 192 T1
// - Alternate criteria: 2048 zeros E1, 1544 T1
// - Update bit rise snapshots and clears counters
// - Mux clear: attenuator clock from master clock
// - Mux set: attenuator clock from PLL
// - Loopback bit routes transmit clock to receive
// - Fallback bit switches to attenuator on loss
// - Mode 4 samples and updates on rising
// - Writes in modes 1,2 capture on falling
// - Writes in modes 3,4 capture on rising
// - Command byte LSB first: rw, address, burst
// - Chip select high aborts, output floats
// - Edge selects pick sample and output edges
`ifndef LUCC_CTRL_MAP_VH
`define LUCC_CTRL_MAP_VH

// Register offsets and reset value
`define LUCC_ADDR_COMMON_CONTROL_ONE 5'h00
`define LUCC_ADDR_LAST_READ 5'h15
`define LUCC_ADDR_LAST_WRITE 5'h16
`define LUCC_RESET_COMMON_CONTROL_ONE 8'h00

// Field positions of common_control_one
`define LUCC_BIT_LINE_STANDARD 7
`define LUCC_BIT_CARRIER_ALT 5
`define LUCC_BIT_COUNT_UPDATE 4
`define LUCC_BIT_ATTEN_MUX 3
`define LUCC_BIT_TX_TO_ATTEN 2
`define LUCC_BIT_TX_TO_RX 1
`define LUCC_BIT_TX_FALLBACK 0

// Command byte layout
`define LUCC_CMD_RW 0
`define LUCC_CMD_ADDR_LO 1
`define LUCC_CMD_ADDR_HI 5
`define LUCC_CMD_BURST 7

// Carrier loss zero counts
`define LUCC_ZEROS_E1 12'h0FF
`define LUCC_ZEROS_T1 12'h0C0
`define LUCC_ZEROS_E1_ALT 12'h800
`define LUCC_ZEROS_T1_ALT 12'h608

// Transmit clock loss timing
`define LUCC_CLOCK_NS 40
`define LUCC_TX_LOSS_NS 5000
`define LUCC_TX_LOSS_CYCLES (`LUCC_TX_LOSS_NS / `LUCC_CLOCK_NS)

`endif

// File: hw/lucc_sync.v
`timescale 1ns/10ps
// Two-stage synchroniser for a group of pins
module lucc_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Data
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);

    // First stage, read only by the second stage
    reg [WIDTH-1:0] meta_q;

    // Both stages clear to zero on reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

// File: verification/lucc_props.sv
`timescale 1ns/10ps
// Timing relations of the common control block at its ports
module lucc_props #(
    parameter ERR_WIDTH = 16,
    parameter TX_LOSS_CYCLES = 125
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Pins
    input wire chipSelN,
    input wire serialOutEn,
    input wire masterClockIn,
    input wire pllClockIn,
    input wire transmitClockIn,
    input wire rxClockIn,
    input wire rxBitStrobe,
    input wire rxBitZero,
    // Outputs
    input wire [7:0] commonControlOne,
    input wire receiveCarrierLoss,
    input wire [ERR_WIDTH-1:0] errorCountSnap,
    input wire attenuatorClock,
    input wire rxClockPath,
    input wire txClockLost
);
    // Cycles since reset; early $past values still see reset
    reg [2:0] upCnt_q;
    // Consecutive zeros seen, saturating
    reg [11:0] zeroCnt_q;
    // Cycles since the transmit clock pin moved
    reg [15:0] idleCnt_q;
    reg txPrev_q;
    wire [7:0] ccr = commonControlOne;
    // Zero count threshold from alternate and standard bits
    wire [11:0] thr = ccr[5] ? (ccr[7] ? 12'h608 : 12'h800) : (ccr[7] ? 12'h0C0 : 12'h0FF);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Helper counters
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            upCnt_q <= 3'h0;
            zeroCnt_q <= 12'h000;
            idleCnt_q <= 16'h0000;
            txPrev_q <= 1'b0;
        end else begin
            if (upCnt_q != 3'h4) begin
                upCnt_q <= upCnt_q + 3'h1;
            end
            if (rxBitStrobe) begin
                zeroCnt_q <= rxBitZero ? zeroCnt_q + {11'h0, zeroCnt_q != 12'hFFF} : 12'h000;
            end
            txPrev_q <= transmitClockIn;
            idleCnt_q <= (transmitClockIn != txPrev_q) ? 16'h0000 : idleCnt_q + 16'h1;
        end
    end
    chk_atten_src: assert property ((upCnt_q == 3'h4) && ccr == $past(ccr, 4) |->
        attenuatorClock == (ccr[2] ? $past(transmitClockIn, 3) : ccr[3] ?
        $past(pllClockIn, 3) : $past(masterClockIn, 3))) else $error("attenuator source");
    chk_rx_path: assert property ((upCnt_q == 3'h4) && ccr == $past(ccr, 4) |->
        rxClockPath == (ccr[1] ? $past(transmitClockIn, 3) : $past(rxClockIn, 3)))
        else $error("receive clock path");
    chk_tx_loss: assert property (idleCnt_q == TX_LOSS_CYCLES + 4 |-> txClockLost)
        else $error("transmit loss missed");
    chk_loss_early: assert property ($rose(receiveCarrierLoss) |-> zeroCnt_q >= thr)
        else $error("carrier loss early");
    chk_loss_late: assert property (zeroCnt_q == thr |-> ##[0:2] receiveCarrierLoss)
        else $error("carrier loss late");
    chk_snap_when: assert property ($changed(errorCountSnap) |->
        ($past(ccr[4]) && !$past(ccr[4], 2)) || ($past(ccr[4], 2) && !$past(ccr[4], 3)))
        else $error("snapshot without trigger");
    chk_reg_quiet: assert property (chipSelN [*6] |=> $stable(commonControlOne))
        else $error("register moved while deselected");
    chk_out_float: assert property (chipSelN [*4] |-> !serialOutEn)
        else $error("output driven while deselected");
endmodule
bind lucc_common_ctrl lucc_props #(.ERR_WIDTH(ERR_WIDTH), .TX_LOSS_CYCLES(TX_LOSS_CYCLES))
    u_props (.clock(clock), .rst_n(rst_n), .chipSelN(chipSelN), .serialOutEn(serialOutEn),
    .masterClockIn(masterClockIn), .pllClockIn(pllClockIn), .rxClockIn(rxClockIn),
    .transmitClockIn(transmitClockIn), .rxBitStrobe(rxBitStrobe), .rxBitZero(rxBitZero),
    .commonControlOne(commonControlOne), .receiveCarrierLoss(receiveCarrierLoss),
    .errorCountSnap(errorCountSnap), .attenuatorClock(attenuatorClock),
    .rxClockPath(rxClockPath), .txClockLost(txClockLost));

// File: verification/lucc_host.sv
`timescale 1ns/10ps
// Host on the serial port; serial clock idles low between frames
module lucc_host (
    // System clock used as time base
    input wire clock,
    // Serial pins
    output logic chipSelN,
    output logic serialClk,
    output logic serialIn,
    output logic inputEdgeSelect,
    output logic outputEdgeSelect,
    input wire serialOut,
    input wire serialOutEn
);
    initial begin
        chipSelN = 1'b1;
        serialClk = 1'b0;
        serialIn = 1'b0;
        inputEdgeSelect = 1'b0;
        outputEdgeSelect = 1'b0;
    end
    // Wait n falling edges of the system clock
    task automatic pause(input int n);
        repeat (n) @(negedge clock);
    endtask
    // One access; a read captures each bit just before the next output edge
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wr, output logic [7:0] rd);
        logic [15:0] bits;
        int smp;
        int oc;
        logic up;
        bits = {wr, cmd};
        smp = 0;
        oc = 0;
        rd = 8'h00;
        pause(1);
        chipSelN = 1'b0;
        for (int s = 0; s < (cmd[0] ? 18 : 16); s++) begin
            // Data moves mid low phase, away from both serial edges
            pause(2);
            serialIn = (s < 16) ? bits[s] : ~serialIn;
            pause(2);
            for (int e = 0; e < 2; e++) begin
                up = (e == 0);
                if (smp >= 8 && up == outputEdgeSelect) begin
                    if (oc >= 1 && oc <= 8) begin
                        rd[oc-1] = serialOut;
                    end
                    oc++;
                end
                serialClk = up;
                smp += (up != inputEdgeSelect);
                if (up) begin
                    pause(4);
                end
            end
        end
        pause(6);
        chipSelN = 1'b1;
        serialIn = ~serialIn;
    endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the common control block
module testbench;
    // Clock, reset and pins
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic masterClockIn = 1'b0;
    logic pllClockIn = 1'b0;
    logic transmitClockIn = 1'b0;
    logic rxClockIn = 1'b0;
    logic rxBitStrobe = 1'b0;
    logic rxBitZero = 1'b0;
    logic errorEvent = 1'b0;
    logic txRun = 1'b1;
    logic [7:0] tick = 8'h00;
    wire chipSelN, serialClk, serialIn, serialOut, serialOutEn;
    wire inputEdgeSelect, outputEdgeSelect, lineStandardT1, receiveCarrierLoss;
    wire attenuatorClock, rxClockPath, txLogicClock, txClockLost;
    wire [7:0] ccr;
    wire [15:0] snap;
    int fail_count = 0;
    int check_count = 0;
    logic [7:0] junk;
    // Register values per mode; mux and standard kept to legal pairs
    logic [7:0] vals [4] = '{8'h8A, 8'h25, 8'h03, 8'hA0};
    int thrs [4] = '{255, 192, 2048, 1544};
    always #20 clock = ~clock;
    // Line clock pins at different power-of-two rates from one counter; transmit clock can stop
    always @(negedge clock) begin
        tick <= tick + 8'h01;
        masterClockIn <= tick[3];
        pllClockIn <= tick[2];
        rxClockIn <= tick[4];
        if (txRun) begin
            transmitClockIn <= tick[1];
        end
    end
    lucc_common_ctrl #(.ERR_WIDTH(16), .TX_LOSS_CYCLES(8)) u_dut (.clock(clock), .rst_n(rst_n),
        .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .inputEdgeSelect(inputEdgeSelect),
        .outputEdgeSelect(outputEdgeSelect), .masterClockIn(masterClockIn),
        .pllClockIn(pllClockIn), .transmitClockIn(transmitClockIn), .rxClockIn(rxClockIn),
        .rxBitStrobe(rxBitStrobe), .rxBitZero(rxBitZero), .errorEvent(errorEvent),
        .commonControlOne(ccr), .lineStandardT1(lineStandardT1),
        .receiveCarrierLoss(receiveCarrierLoss), .errorCountSnap(snap),
        .attenuatorClock(attenuatorClock), .rxClockPath(rxClockPath),
        .txLogicClock(txLogicClock), .txClockLost(txClockLost));
    lucc_host u_host (.clock(clock), .chipSelN(chipSelN), .serialClk(serialClk),
        .serialIn(serialIn), .inputEdgeSelect(inputEdgeSelect), .serialOut(serialOut),
        .outputEdgeSelect(outputEdgeSelect), .serialOutEn(serialOutEn));
    // Compare one value, report at once
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        u_host.xfer({2'b00, a, 1'b0}, d, junk);
    endtask
    task automatic rreg(input logic [4:0] a, input logic [7:0] exp, input string what);
        logic [7:0] got;
        u_host.xfer({2'b00, a, 1'b1}, 8'h00, got);
        check({8'h00, got}, {8'h00, exp}, what);
    endtask
    // Received bits; zero set means the bit is a zero
    task automatic bits(input int n, input logic zero);
        repeat (n) begin
            @(negedge clock);
            rxBitStrobe = 1'b1;
            rxBitZero = zero;
        end
        @(negedge clock);
        rxBitStrobe = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog at about four times the expected run
    initial begin
        #1200000;
        fail_count++;
        end_sim;
    end
    initial begin
        int tog;
        logic prev;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        rreg(5'h00, 8'h00, "reset value");
        // Every edge mode: ice is high in modes 1 and 2, oce high in 1 and 4
        for (int m = 0; m < 4; m++) begin
            u_host.inputEdgeSelect = ~m[1];
            u_host.outputEdgeSelect = ~(m[0] ^ m[1]);
            wreg(5'h00, vals[m]);
            rreg(5'h00, vals[m], "mode readback");
            check({15'h0, lineStandardT1}, {15'h0, vals[m][7]}, "standard");
            check({15'h0, serialOutEn}, 16'h0, "output float");
        end
        wreg(5'h01, 8'hFF);
        rreg(5'h00, 8'hA0, "write elsewhere");
        rreg(5'h01, 8'h00, "read elsewhere");
        // Burst access starts at address zero whatever address it names
        u_host.xfer(8'h8A, 8'h26, junk);
        u_host.xfer(8'h8B, 8'h00, junk);
        check({8'h00, junk}, 16'h0026, "burst from zero");
        // A burst read drives until deselected, so the float is real
        repeat (4) @(negedge clock);
        check({15'h0, serialOutEn}, 16'h0, "burst float");
        $display("test serial access done");
        // Carrier loss thresholds for both standards and criteria
        for (int k = 0; k < 4; k++) begin
            wreg(5'h00, {k[0], 1'b0, k[1], 5'h00});
            bits(1, 1'b0);
            bits(thrs[k] - 1, 1'b1);
            check({15'h0, receiveCarrierLoss}, 16'h0, "loss early");
            bits(1, 1'b1);
            check({15'h0, receiveCarrierLoss}, 16'h1, "loss due");
            bits(1, 1'b0);
            check({15'h0, receiveCarrierLoss}, 16'h0, "loss cleared");
        end
        $display("test carrier loss done");
        // Two snapshots; the second shows the running count was cleared
        for (int n = 5; n > 2; n -= 2) begin
            wreg(5'h00, 8'h00);
            repeat (n) begin
                @(negedge clock);
                errorEvent = 1'b1;
                @(negedge clock);
                errorEvent = 1'b0;
            end
            wreg(5'h00, 8'h10);
            repeat (2) @(negedge clock);
            check(snap, n[15:0], "error snapshot");
        end
        $display("test error snapshot done");
        // Stop the transmit clock, with and without fallback
        wreg(5'h00, 8'h01);
        txRun = 1'b0;
        repeat (40) @(negedge clock);
        check({15'h0, txClockLost}, 16'h1, "clock lost");
        for (int f = 1; f >= 0; f--) begin
            if (f == 0) begin
                wreg(5'h00, 8'h00);
            end
            tog = 0;
            prev = txLogicClock;
            repeat (64) begin
                @(negedge clock);
                tog += (txLogicClock !== prev);
                prev = txLogicClock;
            end
            check({15'h0, tog != 0}, f[15:0], "fallback clock");
        end
        txRun = 1'b1;
        repeat (20) @(negedge clock);
        check({15'h0, txClockLost}, 16'h0, "clock back");
        $display("test transmit clock done");
        end_sim;
    end
endmodule
